// File: core/dpr_pkg.sv
package dpr_pkg;
  // ==========================================================
  // geometry of the storage array
  localparam int ADDR_W = 13;
  localparam int DATA_W = 36;
  localparam int BE_W = 4;
  localparam int ROW_AW = 8;
  localparam int ROWS = 256;
  localparam int OFF_W = 6;
  localparam int DEP_W = 14;
  localparam int ROW_BITS = 36;
  localparam logic [DEP_W-1:0] DEPTH_MIN = 14'h0100;
  localparam logic [DEP_W-1:0] DEPTH_MAX = 14'h2000;
  localparam logic [DEP_W-1:0] DEPTH_RST = 14'h2000;

  // width codes: 0..5 = 1,2,4,8,16,32 bits; 6..8 = 9,18,36 bits
  localparam logic [3:0] W_POW_TOP = 4'h5;
  localparam logic [3:0] W_NINE_LOW = 4'h6;
  localparam logic [3:0] W_NINE_MID = 4'h7;
  localparam logic [3:0] W_LAST = 4'h8;

  // ==========================================================
  // modes
  typedef enum logic [1:0] {OP_SINGLE = 2'h0, OP_SIMPLE = 2'h1, OP_TRUE = 2'h3} dpr_op_e;
  typedef enum logic [1:0] {CK_SINGLE = 2'h0, CK_INOUT = 2'h1, CK_INDEP = 2'h3,
                            CK_RDWR = 2'h2} dpr_clk_e;
  typedef enum logic [1:0] {SP_DONTCARE = 2'h0, SP_NEW = 2'h1, SP_OLD = 2'h3} dpr_sp_e;
  typedef enum logic {MP_OLD = 1'b0, MP_DONTCARE = 1'b1} dpr_mp_e;

  typedef struct packed {
    logic [5:0] bits; // data bits of one word
    logic [2:0] prl;  // log2 of words per row
    logic [3:0] dlog; // log2 of port depth
    logic nine;       // 9-bit byte family
  } dpr_wid_s;

  typedef struct packed {
    logic [ROW_AW-1:0] row;
    logic [OFF_W-1:0] off;
  } dpr_loc_s;

  // ==========================================================
  // register map of the controller end (byte addresses)
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_ENA = 8'h04;
  localparam logic [7:0] A_CMD_A = 8'h08;
  localparam logic [7:0] A_WD_A = 8'h0c;
  localparam logic [7:0] A_CMD_B = 8'h10;
  localparam logic [7:0] A_WD_B = 8'h14;
  localparam logic [7:0] A_GO = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_RD_A = 8'h20;
  localparam logic [7:0] A_RD_B = 8'h24;
  localparam logic [3:0] ENA_RST = 4'hf;
  // CMD fields: [12:0] addr, [16:13] be, [17] we, [18] re, [19] keep, [23:20] wdata hi
  localparam int CMD_BE = 13;
  localparam int CMD_WE = 17;
  localparam int CMD_RE = 18;
  localparam int CMD_KEEP = 19;
  localparam int CMD_HI = 20;
  localparam logic [1:0] LAT_OUTREG = 2'h1;

  function automatic dpr_wid_s dpr_wid(input logic [3:0] c);
    case (c)
      4'h0: dpr_wid = '{6'h01, 3'h5, 4'hd, 1'b0};
      4'h1: dpr_wid = '{6'h02, 3'h4, 4'hc, 1'b0};
      4'h2: dpr_wid = '{6'h04, 3'h3, 4'hb, 1'b0};
      4'h3: dpr_wid = '{6'h08, 3'h2, 4'ha, 1'b0};
      4'h4: dpr_wid = '{6'h10, 3'h1, 4'h9, 1'b0};
      4'h5: dpr_wid = '{6'h20, 3'h0, 4'h8, 1'b0};
      4'h6: dpr_wid = '{6'h09, 3'h2, 4'ha, 1'b1};
      4'h7: dpr_wid = '{6'h12, 3'h1, 4'h9, 1'b1};
      default: dpr_wid = '{6'h24, 3'h0, 4'h8, 1'b1};
    endcase
  endfunction : dpr_wid

  // row of the array and bit offset inside it for one word address
  function automatic dpr_loc_s dpr_loc(input logic [3:0] c, input logic [ADDR_W-1:0] a);
    dpr_wid_s w;
    logic [ADDR_W-1:0] lane;
    w = dpr_wid(c);
    lane = a & ~(13'h1fff << w.prl);
    dpr_loc.row = ROW_AW'(a >> w.prl);
    dpr_loc.off = OFF_W'(lane * w.bits);
  endfunction : dpr_loc
endpackage : dpr_pkg

// File: core/dpr_if.sv
`timescale 1ns/1ps
// link between the memory block and the logic that uses it
interface dpr_if;
  logic [1:0] op;                      // operating mode
  logic [1:0] clk_mode;                // clocking scheme
  logic [3:0] wid_a;                   // width code port A
  logic [3:0] wid_b;                   // width code port B
  logic [1:0] sp_rdw;                  // same-port read-during-write choice
  logic mp_rdw;                        // mixed-port read-during-write choice
  logic out_reg;                       // use output registers
  logic [13:0] max_depth;              // maximum block depth in words
  logic [3:0] en;                      // {b_out, b_in, a_out, a_in} enables
  logic [1:0][12:0] addr;              // word address per port
  logic [1:0][35:0] wdata;             // write data per port
  logic [1:0][3:0] be;                 // byte enables per port
  logic [1:0] we;                      // write enable per port
  logic [1:0] re;                      // read enable per port
  logic [1:0][35:0] q;                 // read data per port
  logic [1:0] q_unk;                   // read data not defined
  logic cfg_err;                       // configuration refused
  logic ready;                         // array cleared and usable

  modport dev (input op, clk_mode, wid_a, wid_b, sp_rdw, mp_rdw, out_reg, max_depth, en,
               addr, wdata, be, we, re, output q, q_unk, cfg_err, ready);
  modport usr (output op, clk_mode, wid_a, wid_b, sp_rdw, mp_rdw, out_reg, max_depth, en,
               addr, wdata, be, we, re, input q, q_unk, cfg_err, ready);
endinterface : dpr_if

// File: core/dpr_mem_dev.sv
`timescale 1ns/1ps
module dpr_mem_dev (
  dpr_if.dev LNK,      // memory ports and configuration
  input wire logic CLK_SYS, // system clock
  input wire logic RST_N,   // synchronous reset, low active
  output logic CFG_ERR,     // configuration refused
  output logic READY,       // clear sweep finished
  output logic WR_CLASH     // both ports wrote one word last edge
);
  localparam int DW = dpr_pkg::DATA_W;
  localparam logic [DW-1:0] ONES = 36'hf_ffff_ffff;

  logic [DW-1:0] mem [dpr_pkg::ROWS];
  logic clr_r;
  logic [dpr_pkg::ROW_AW-1:0] clr_idx_r;
  logic cfg_ok, mode_ok, dep_ok, fit_ok, same_fam;
  dpr_pkg::dpr_wid_s [1:0] wid;
  dpr_pkg::dpr_loc_s [1:0] loc;
  logic [1:0] ein, eout, wr_role, rd_role, act_we, act_re, unk;
  logic [1:0][DW-1:0] wmask0, lmask, wmask, wd, old, newr, rsel, rval;
  logic [7:0] be_x;
  logic [1:0][DW-1:0] q_lat_r, q_reg_r;
  logic [1:0] unk_lat_r, unk_reg_r;
  logic clash, clash_r;
  logic mix_unk_mode;

  // ==========================================================
  // configuration check
  always_comb begin
    wid[0] = dpr_pkg::dpr_wid(LNK.wid_a);
    wid[1] = dpr_pkg::dpr_wid(LNK.wid_b);
    same_fam = (wid[0].nine == wid[1].nine);
    dep_ok = ((LNK.max_depth & (LNK.max_depth - 14'h0001)) == 14'h0000)
             && (LNK.max_depth >= dpr_pkg::DEPTH_MIN)
             && (LNK.max_depth <= dpr_pkg::DEPTH_MAX);
    // a sliced block keeps fewer words, so deep narrow ports no longer fit
    fit_ok = ((14'h0001 << wid[0].dlog) <= LNK.max_depth)
             && ((LNK.op == dpr_pkg::OP_SINGLE)
                 || ((14'h0001 << wid[1].dlog) <= LNK.max_depth));
    case (LNK.op)
      dpr_pkg::OP_SINGLE: begin
        mode_ok = (LNK.wid_a <= dpr_pkg::W_LAST)
                  && ((LNK.clk_mode == dpr_pkg::CK_SINGLE)
                      || (LNK.clk_mode == dpr_pkg::CK_INOUT));
      end
      dpr_pkg::OP_SIMPLE: begin
        mode_ok = (LNK.wid_a <= dpr_pkg::W_LAST) && (LNK.wid_b <= dpr_pkg::W_LAST)
                  && same_fam
                  && (LNK.clk_mode != dpr_pkg::CK_INDEP);
      end
      dpr_pkg::OP_TRUE: begin
        mode_ok = same_fam
                  && (LNK.wid_a <= dpr_pkg::W_NINE_MID) && (LNK.wid_a != dpr_pkg::W_POW_TOP)
                  && (LNK.wid_b <= dpr_pkg::W_NINE_MID) && (LNK.wid_b != dpr_pkg::W_POW_TOP)
                  && (LNK.clk_mode != dpr_pkg::CK_RDWR);
      end
      default: mode_ok = 1'b0;
    endcase
    cfg_ok = mode_ok && dep_ok && fit_ok;
  end

  // ==========================================================
  // which enable qualifies which register group
  always_comb begin
    case (LNK.clk_mode)
      dpr_pkg::CK_SINGLE: begin
        ein = {2{LNK.en[0]}};
        eout = {2{LNK.en[0]}};
      end
      dpr_pkg::CK_INOUT: begin
        ein = {2{LNK.en[0]}};
        eout = {2{LNK.en[1]}};
      end
      dpr_pkg::CK_INDEP: begin
        ein = {LNK.en[2], LNK.en[0]};
        eout = {LNK.en[3], LNK.en[1]};
      end
      default: begin
        ein = {LNK.en[2], LNK.en[0]};
        eout = {LNK.en[3], LNK.en[1]};
      end
    endcase
  end

  // port A writes in every mode, port B only in true dual-port;
  // port B reads in both dual-port modes, port A not in simple dual-port
  assign wr_role = {LNK.op == dpr_pkg::OP_TRUE, 1'b1};
  assign rd_role = {LNK.op != dpr_pkg::OP_SINGLE, LNK.op != dpr_pkg::OP_SIMPLE};
  assign mix_unk_mode = (LNK.mp_rdw == dpr_pkg::MP_DONTCARE)
                        || (LNK.clk_mode == dpr_pkg::CK_INDEP)
                        || (LNK.clk_mode == dpr_pkg::CK_RDWR);

  // ==========================================================
  // per-port address decode, masks and read selection
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      loc[p] = dpr_pkg::dpr_loc(p == 0 ? LNK.wid_a : LNK.wid_b, LNK.addr[p]);
      act_we[p] = cfg_ok && !clr_r && ein[p] && LNK.we[p] && wr_role[p];
      act_re[p] = cfg_ok && !clr_r && ein[p] && LNK.re[p] && rd_role[p];
      be_x = {4'h0, LNK.be[p]};
      for (int i = 0; i < DW; i++) begin
        // a byte is 9 bits in the nine family, 8 otherwise
        wmask0[p][i] = be_x[wid[p].nine ? 3'(i / 9) : 3'(i / 8)];
      end
      lmask[p] = DW'(~(ONES << wid[p].bits));
      wmask0[p] = wmask0[p] & lmask[p];
      lmask[p] = DW'(lmask[p] << loc[p].off);
      wmask[p] = act_we[p] ? DW'(wmask0[p] << loc[p].off) : 36'h0;
      wd[p] = DW'(LNK.wdata[p] << loc[p].off);
      old[p] = mem[loc[p].row];
    end
    newr[0] = (old[0] & ~wmask[0]) | (wd[0] & wmask[0]);
    // a write on A into the same row must survive B's row update
    newr[1] = ((act_we[0] && (loc[0].row == loc[1].row)) ? newr[0] : old[1]) & ~wmask[1];
    newr[1] = newr[1] | (wd[1] & wmask[1]);
    for (int p = 0; p < 2; p++) begin
      if (act_we[p] && (LNK.sp_rdw == dpr_pkg::SP_NEW)) begin
        rsel[p] = (old[p] & ~wmask[p]) | (wd[p] & wmask[p]);
      end else begin
        rsel[p] = old[p];
      end
      rval[p] = DW'(rsel[p] >> loc[p].off) & DW'(lmask[p] >> loc[p].off);
      unk[p] = mix_unk_mode && (loc[0].row == loc[1].row)
               && ((lmask[p] & wmask[1-p]) != 36'h0) && !act_we[p];
    end
    clash = act_we[0] && act_we[1] && (loc[0].row == loc[1].row)
            && ((wmask[0] & wmask[1]) != 36'h0);
  end

  // ==========================================================
  // storage: zero sweep after reset, then port writes
  always_ff @(posedge CLK_SYS) begin
    if (clr_r) begin
      mem[clr_idx_r] <= 36'h0;
    end else begin
      if (act_we[0]) begin
        mem[loc[0].row] <= newr[0];
      end
      if (act_we[1]) begin
        mem[loc[1].row] <= newr[1]; // port B wins a clash
      end
    end
  end

  // sweep counter; 256 cycles keeps ports blocked but avoids a huge reset fan-out
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      clr_r <= 1'b1;
      clr_idx_r <= 8'h00;
    end else if (clr_r) begin
      clr_idx_r <= clr_idx_r + 8'h01;
      clr_r <= (clr_idx_r != 8'(dpr_pkg::ROWS - 1));
    end
  end

  // ==========================================================
  // read latches, held while read enable is low
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q_lat_r <= '0;
      unk_lat_r <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (act_re[p]) begin
          q_lat_r[p] <= rval[p];
          unk_lat_r[p] <= unk[p];
        end
      end
    end
  end

  // optional output registers on the output enable
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q_reg_r <= '0;
      unk_reg_r <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (eout[p]) begin
          q_reg_r[p] <= q_lat_r[p];
          unk_reg_r[p] <= unk_lat_r[p];
        end
      end
    end
  end

  // clash flag, one cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      clash_r <= 1'b0;
    end else begin
      clash_r <= clash;
    end
  end

  assign LNK.q = LNK.out_reg ? q_reg_r : q_lat_r;
  assign LNK.q_unk = LNK.out_reg ? unk_reg_r : unk_lat_r;
  assign LNK.cfg_err = !cfg_ok;
  assign LNK.ready = !clr_r;
  assign CFG_ERR = !cfg_ok;
  assign READY = !clr_r;
  assign WR_CLASH = clash_r;
endmodule : dpr_mem_dev

// File: core/dpr_usr_end.sv
`timescale 1ns/1ps
// user-side controller: software sets up and fires memory operations over APB
module dpr_usr_end (
  dpr_if.usr LNK,             // memory ports and configuration
  input wire logic CLK_SYS,   // system clock
  input wire logic RST_N,     // synchronous reset, low active
  input wire logic PSEL,      // APB select
  input wire logic PENABLE,   // APB access phase
  input wire logic PWRITE,    // APB direction
  input wire logic [7:0] PADDR,   // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY,        // APB ready
  output logic PSLVERR        // APB error on unmapped address
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ISSUE = 2'h1, ST_WAIT = 2'h3} dpr_seq_e;

  dpr_seq_e st_r;
  logic [29:0] cfg_r;
  logic [3:0] ena_r;
  logic [1:0][23:0] cmd_r;
  logic [1:0][31:0] wdat_r;
  logic [1:0][35:0] rdat_r;
  logic [1:0] unk_r, go_we, go_re;
  logic [1:0] cnt_r;
  logic done_r, drop_r, wr, go, clash;
  logic [1:0][12:0] addr_r;
  logic [1:0][35:0] wd_r;
  logic [1:0][3:0] be_r;
  logic [1:0] we_r, re_r;
  logic [31:0] rd_mux;
  logic hit;
  dpr_pkg::dpr_loc_s la, lb;
  dpr_pkg::dpr_wid_s wa, wb;

  // ==========================================================
  // APB write side
  assign wr = PSEL && PENABLE && PWRITE;
  // a request made while the memory is not ready, busy or misconfigured is dropped
  assign go = wr && (PADDR == dpr_pkg::A_GO) && (st_r == ST_IDLE) && LNK.ready
              && !LNK.cfg_err;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cfg_r <= {dpr_pkg::DEPTH_RST, 16'h0000};
      ena_r <= dpr_pkg::ENA_RST;
      cmd_r <= '0;
      wdat_r <= '0;
    end else if (wr) begin
      case (PADDR)
        dpr_pkg::A_CFG: cfg_r <= PWDATA[29:0];
        dpr_pkg::A_ENA: ena_r <= PWDATA[3:0];
        dpr_pkg::A_CMD_A: cmd_r[0] <= PWDATA[23:0];
        dpr_pkg::A_WD_A: wdat_r[0] <= PWDATA;
        dpr_pkg::A_CMD_B: cmd_r[1] <= PWDATA[23:0];
        dpr_pkg::A_WD_B: wdat_r[1] <= PWDATA;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // ==========================================================
  // collision check between the two write requests
  always_comb begin
    wa = dpr_pkg::dpr_wid(cfg_r[7:4]);
    wb = dpr_pkg::dpr_wid(cfg_r[11:8]);
    la = dpr_pkg::dpr_loc(cfg_r[7:4], cmd_r[0][12:0]);
    lb = dpr_pkg::dpr_loc(cfg_r[11:8], cmd_r[1][12:0]);
    clash = PWDATA[0] && PWDATA[1] && cmd_r[0][dpr_pkg::CMD_WE] && cmd_r[1][dpr_pkg::CMD_WE]
            && (la.row == lb.row)
            && ({1'b0, la.off} < 7'(lb.off + wb.bits))
            && ({1'b0, lb.off} < 7'(la.off + wa.bits));
    for (int p = 0; p < 2; p++) begin
      go_we[p] = PWDATA[p] && cmd_r[p][dpr_pkg::CMD_WE] && !((p == 1) && clash);
      // read enable stays low on writes unless the read-during-write value is wanted
      go_re[p] = PWDATA[p] && cmd_r[p][dpr_pkg::CMD_RE]
                 && (!cmd_r[p][dpr_pkg::CMD_WE] || cmd_r[p][dpr_pkg::CMD_KEEP]);
    end
  end

  // ==========================================================
  // sequencer: issue one cycle, wait the read latency, capture
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_r <= ST_IDLE;
      cnt_r <= 2'h0;
      done_r <= 1'b0;
      drop_r <= 1'b0;
      we_r <= 2'h0;
      re_r <= 2'h0;
      addr_r <= '0;
      wd_r <= '0;
      be_r <= '0;
      rdat_r <= '0;
      unk_r <= 2'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r <= ST_ISSUE;
            done_r <= 1'b0;
            drop_r <= clash;
            we_r <= go_we;
            re_r <= go_re;
            for (int p = 0; p < 2; p++) begin
              addr_r[p] <= cmd_r[p][12:0];
              be_r[p] <= cmd_r[p][dpr_pkg::CMD_BE +: 4];
              wd_r[p] <= {cmd_r[p][dpr_pkg::CMD_HI +: 4], wdat_r[p]};
            end
          end
        end
        ST_ISSUE: begin
          st_r <= ST_WAIT;
          we_r <= 2'h0;
          re_r <= 2'h0;
          cnt_r <= cfg_r[15] ? dpr_pkg::LAT_OUTREG : 2'h0;
        end
        ST_WAIT: begin
          if (cnt_r == 2'h0) begin
            st_r <= ST_IDLE;
            done_r <= 1'b1;
            rdat_r <= LNK.q;
            unk_r <= LNK.q_unk;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // APB read side, data registered in the setup cycle
  always_comb begin
    hit = 1'b1;
    case (PADDR)
      dpr_pkg::A_CFG: rd_mux = {2'h0, cfg_r};
      dpr_pkg::A_ENA: rd_mux = {28'h0, ena_r};
      dpr_pkg::A_CMD_A: rd_mux = {8'h00, cmd_r[0]};
      dpr_pkg::A_WD_A: rd_mux = wdat_r[0];
      dpr_pkg::A_CMD_B: rd_mux = {8'h00, cmd_r[1]};
      dpr_pkg::A_WD_B: rd_mux = wdat_r[1];
      dpr_pkg::A_GO: rd_mux = 32'h0;
      dpr_pkg::A_STAT: rd_mux = {16'h0000, rdat_r[1][35:32], rdat_r[0][35:32], 1'b0, drop_r,
                                 unk_r, LNK.ready, LNK.cfg_err, done_r, st_r != ST_IDLE};
      dpr_pkg::A_RD_A: rd_mux = rdat_r[0][31:0];
      dpr_pkg::A_RD_B: rd_mux = rdat_r[1][31:0];
      default: begin
        rd_mux = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h0 : rd_mux;
      PSLVERR <= !hit;
    end
  end

  assign PREADY = 1'b1;

  // configuration and port drive toward the memory
  assign LNK.op = cfg_r[1:0];
  assign LNK.clk_mode = cfg_r[3:2];
  assign LNK.wid_a = cfg_r[7:4];
  assign LNK.wid_b = cfg_r[11:8];
  assign LNK.sp_rdw = cfg_r[13:12];
  assign LNK.mp_rdw = cfg_r[14];
  assign LNK.out_reg = cfg_r[15];
  assign LNK.max_depth = cfg_r[29:16];
  assign LNK.en = ena_r;
  assign LNK.addr = addr_r;
  assign LNK.wdata = wd_r;
  assign LNK.be = be_r;
  assign LNK.we = we_r;
  assign LNK.re = re_r;
endmodule : dpr_usr_end

// File: dv/dpr_props.sv
`timescale 1ns/1ps
// ==========================================================
// link checks between user end and memory
module dpr_props (
  input wire logic CLK_SYS, // clock
  input wire logic RST_N, // sync reset
  input wire logic [1:0] op, // mode
  input wire logic [1:0] clk_mode, // clocking
  input wire logic [3:0] wid_a, // width a
  input wire logic [3:0] wid_b, // width b
  input wire logic mp_rdw, // mixed choice
  input wire logic out_reg, // output regs
  input wire logic [13:0] max_depth, // depth
  input wire logic [3:0] en, // enables
  input wire logic [1:0][12:0] addr, // address
  input wire logic [1:0][3:0] be, // byte enables
  input wire logic [1:0] we, // write
  input wire logic [1:0] re, // read
  input wire logic [1:0][35:0] q, // data out
  input wire logic [1:0] q_unk, // undefined
  input wire logic cfg_err, // refused
  input wire logic ready // swept
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic [8:0] cnt_r;
  logic hit;
  // edges since release, saturates so it never wraps into the sweep window
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) cnt_r <= 9'h000;
    else if (cnt_r != 9'h1ff) cnt_r <= cnt_r + 9'h001;
  end
  // port a writes the word port b reads, same width, all enables on
  // byte 0 is in every width, so its enable guarantees a real overlap
  assign hit = op != 2'h0 && we[0] && be[0][0] && re[1] && addr[0] == addr[1] && en == 4'hf &&
               ready && !cfg_err && !out_reg && wid_a == wid_b;
  sequence s_idle; !re[0] && !out_reg; endsequence
  sequence s_keep; !out_reg; endsequence
  a_q_reset_zero: assert property ($rose(RST_N) |-> q == '0 && q_unk == 2'h0)
    else $error("read data not clear after reset");
  a_ready_sweep: assert property (ready == (cnt_r >= 9'h100))
    else $error("ready out of step with clear sweep");
  a_depth_bad: assert property ((max_depth < 14'h0100 || max_depth > 14'h2000 ||
    (max_depth & (max_depth - 14'h0001)) != 14'h0000) |-> cfg_err)
    else $error("bad block depth accepted");
  a_true_wide: assert property (op == 2'h3 && (wid_a inside {4'h5, 4'h8} ||
    wid_b inside {4'h5, 4'h8}) |-> cfg_err)
    else $error("wide word accepted in true dual");
  a_family_mix: assert property (op != 2'h0 && (wid_a > 4'h5) != (wid_b > 4'h5) |-> cfg_err)
    else $error("width families mixed");
  a_clock_mode: assert property ((op != 2'h3 && clk_mode == 2'h3) ||
    (op == 2'h0 && clk_mode == 2'h2) |-> cfg_err)
    else $error("clocking accepted for wrong mode");
  a_mixed_unknown: assert property (hit && mp_rdw |=> q_unk[1])
    else $error("mixed collision not flagged");
  a_read_hold: assert property (s_idle ##1 s_keep |-> $stable(q[0]))
    else $error("read data moved without read");
endmodule : dpr_props

// File: dv/dual_port_block_ram_rdw_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench: both ends joined, software side driven over apb
module dual_port_block_ram_rdw_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st, ra, rb;
  logic pready, pslverr, cfg_err, ready, clash, err;
  logic [17:0] mdl [512] = '{default: 18'h0}; // expected contents, zero at start
  int fail_count = 0, total_checks = 0, seed = 24;
  dpr_if lnk ();
  dpr_mem_dev i_dpr_mem_dev (.LNK(lnk), .CLK_SYS(clk), .RST_N(rst_n), .CFG_ERR(cfg_err),
    .READY(ready), .WR_CLASH(clash));
  dpr_usr_end i_dpr_usr_end (.LNK(lnk), .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  dpr_props i_dpr_props (.CLK_SYS(clk), .RST_N(rst_n), .op(lnk.op), .clk_mode(lnk.clk_mode),
    .wid_a(lnk.wid_a), .wid_b(lnk.wid_b), .mp_rdw(lnk.mp_rdw), .out_reg(lnk.out_reg),
    .max_depth(lnk.max_depth), .en(lnk.en), .addr(lnk.addr), .be(lnk.be), .we(lnk.we),
    .re(lnk.re),
    .q(lnk.q), .q_unk(lnk.q_unk), .cfg_err(lnk.cfg_err), .ready(lnk.ready));
  // 200 mhz clock
  always #2.5 clk = ~clk;
  // compare one result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // port command word for an x18 port, rdw pass-through always kept
  function automatic logic [31:0] cmd(input int a, input logic [1:0] b, input logic w,
                                      input logic r);
    cmd = {12'h0, 1'b1, r, w, 2'h0, b, 13'(a)};
  endfunction : cmd
  function automatic logic [17:0] mrg(input logic [17:0] o, input logic [17:0] n,
                                      input logic [1:0] b);
    mrg = {b[1] ? n[17:9] : o[17:9], b[0] ? n[8:0] : o[8:0]};
  endfunction : mrg
  // fire both ports, wait for done, fetch status and read words
  task automatic run(input logic [31:0] ca, input logic [31:0] cb, input logic [17:0] da,
                     input logic [17:0] db);
    int k;
    k = 0;
    apb(1'b1, 8'h08, ca);
    apb(1'b1, 8'h0c, 32'(da));
    apb(1'b1, 8'h10, cb);
    apb(1'b1, 8'h14, 32'(db));
    apb(1'b1, 8'h18, 32'h3);
    do begin
      apb(1'b0, 8'h1c, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 20);
    chk(32'(rd[1]), 32'h1);
    st = rd;
    apb(1'b0, 8'h20, 32'h0);
    ra = rd;
    apb(1'b0, 8'h24, 32'h0);
    rb = rd;
  endtask : run
  // write a configuration and see whether it is refused
  task automatic cfg(input logic [31:0] c, input logic e);
    apb(1'b1, 8'h00, c);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(rd[2]), 32'(e));
    chk(32'(cfg_err), 32'(e));
  endtask : cfg
  task automatic results;
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // main sequence
  initial begin
    int a;
    logic [17:0] v, o;
    logic [1:0] sp, b;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2000_0000);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0000_000f);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(rd[3]), 32'h0);
    repeat (260) @(posedge clk);
    cfg(32'h0100_1770, 1'b1);
    cfg(32'h0300_1770, 1'b1);
    cfg(32'h0080_1770, 1'b1);
    cfg(32'h2000_0883, 1'b1);
    cfg(32'h2000_0633, 1'b1);
    cfg(32'h2000_0831, 1'b1);
    cfg(32'h2000_0051, 1'b0);
    cfg(32'h2000_177c, 1'b1);
    cfg(32'h2000_077d, 1'b1);
    cfg(32'h2000_077f, 1'b0);
    cfg(32'h0200_1770, 1'b0);
    chk(32'(rd[3]), 32'h1);
    // same-port write with read: new, don't care and old choices, both output paths
    for (int i = 0; i < 6; i++) begin
      sp = (i < 2) ? 2'h1 : (i < 4) ? 2'h0 : 2'h3;
      a = $random(seed) & 511;
      v = 18'($random(seed));
      b = 2'($random(seed));
      apb(1'b1, 8'h00, 32'h2000_0770 | (32'(sp) << 12) | (32'(i & 1) << 15));
      run(cmd(a, b, 1'b1, 1'b1), 32'h0, v, 18'h0);
      o = mdl[a];
      mdl[a] = mrg(o, v, b);
      chk(ra, 32'(sp == 2'h1 ? mdl[a] : o));
    end
    // clock enables off: a write must not land
    apb(1'b1, 8'h04, 32'h0);
    run(cmd(a, 2'h3, 1'b1, 1'b0), 32'h0, ~v, 18'h0);
    apb(1'b1, 8'h04, 32'hf);
    run(cmd(a, 2'h0, 1'b0, 1'b1), 32'h0, 18'h0, 18'h0);
    chk(ra, 32'(mdl[a]));
    // in/out clocking: output enable low holds the registered word
    apb(1'b1, 8'h00, 32'h2000_8774);
    apb(1'b1, 8'h04, 32'h1);
    run(cmd(a ^ 1, 2'h0, 1'b0, 1'b1), 32'h0, 18'h0, 18'h0);
    chk(ra, 32'(mdl[a]));
    apb(1'b1, 8'h04, 32'hf);
    // mixed collision: old data, don't care, independent clocks
    for (int i = 0; i < 3; i++) begin
      a = $random(seed) & 511;
      v = 18'($random(seed));
      apb(1'b1, 8'h00, i == 0 ? 32'h2000_0771 : i == 1 ? 32'h2000_4771 : 32'h2000_077f);
      run(cmd(a, 2'h3, 1'b1, 1'b0), cmd(a, 2'h0, 1'b0, 1'b1), v, 18'h0);
      chk(rb, 32'(mdl[a]));
      chk(32'(st[5]), 32'(i != 0));
      mdl[a] = v;
    end
    // both ports write one word: port b is dropped
    apb(1'b1, 8'h00, 32'h2000_0773);
    run(cmd(a, 2'h3, 1'b1, 1'b0), cmd(a, 2'h3, 1'b1, 1'b0), v, ~v);
    chk(32'(st[6]), 32'h1);
    run(32'h0, cmd(a, 2'h0, 1'b0, 1'b1), 18'h0, 18'h0);
    chk(rb, 32'(v));
    results();
  end
  // watchdog: the sequence needs under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule : dual_port_block_ram_rdw_tb_top
